// ===== logic/fsps_pkg.sv
/*
  Shared constants for the flash self-program sequencer: register offsets,
  control bit positions, command codes, reset values and timing.
  Assumes a 20 MHz system clock and a 32-bit APB register bus.
*/
package fsps_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PTR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STORE = 8'h0C;
  localparam logic [7:0] OFS_LPM = 8'h10;
  localparam logic [7:0] OFS_LOCK = 8'h14;

  // ****************************************************************
  // Control register bit positions
  // ****************************************************************
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_BUSY = 6;
  localparam int BIT_REEN = 4;
  localparam int BIT_LOCK = 3;
  localparam int BIT_WRITE = 2;
  localparam int BIT_ERASE = 1;
  localparam int BIT_STORE_EN = 0;

  // ****************************************************************
  // Command codes in the low five control bits
  // ****************************************************************
  localparam logic [4:0] CMD_REEN = 5'h11;
  localparam logic [4:0] CMD_LOCK = 5'h09;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_LOAD = 5'h01;

  // ****************************************************************
  // Pointer and lock field positions, reset values
  // ****************************************************************
  localparam int PTR_WORD_LSB = 1;
  localparam int LOCK_DATA_LSB = 2;
  localparam logic [3:0] LOCK_RESET = 4'hF;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] BLOCKED_BYTE = 8'hFF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int ARM_CYCLES = 4;
  localparam int PROG_TIME_NS = 3700000;
  localparam int PROG_CYCLES_DFLT =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 20;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    FSPS_IDLE = 3'b001,
    FSPS_ARMED = 3'b010,
    FSPS_RUN = 3'b100
  } fsps_state_t;

endpackage : fsps_pkg

// ===== logic/fsps_page_buf.sv
/*
  Temporary page buffer storage: one write port, one read port with
  registered read data.
  Assumes a single clock; the caller tracks which words are loaded.
*/
`timescale 1ns/10ps
module fsps_page_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // No reset on the array; loaded words are qualified outside
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : fsps_page_buf

// ===== logic/fsps_sequencer.sv
/*
  Flash self-program sequencer: APB register file, arming window, page
  erase, buffer load, page write and lock bit programming.
  Assumes a zero-wait APB master, a flash array that reads the buffer
  after the write strobe, and a CPU that honours cpu_halt.
*/
// Local design decisions: the placing of the registers and the APB register port.
// Behaviour
// - Store address comes from the 16-bit pointer: page high, word low.
// - Target page latched at operation start; pointer reuse is harmless.
// - Lock bit programming ignores the pointer entirely.
// - Byte reads use pointer bit 0 to select byte within word.
// - Buffer words may be loaded in any order.
// - Erase code then store within four cycles erases; data ignored.
// - Erasing concurrent section keeps stalling readable; else CPU halts.
// - Load code then store within four cycles writes data at word index.
// - Buffer clears after page write, on re-enable, and at reset.
// - EEPROM write during loading discards all loaded buffer data.
// - Write code then store within four cycles programs latched page.
// - Writing concurrent section keeps stalling readable; else CPU halts.
// - Ready interrupt stays high while enabled and store enable clear.
// - Erase or write of concurrent section blocks it, busy flag set.
// - Lock code then store programs lock bits where data bits 5:2 zero.
// - Lock programming leaves the whole flash readable.
// - Store enable arms four cycles; held through erase and write.
`timescale 1ns/10ps
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int WORD_BITS = 6,
  parameter int PAGE_BITS = 7,
  parameter int STALL_FIRST_PAGE = 112,
  parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eeprom_write,
  input wire logic [15:0] flash_word,
  output logic [14:0] lpm_word_addr,
  input wire logic [WORD_BITS-1:0] buf_rd_addr,
  output logic [15:0] buf_rd_data,
  output logic buf_rd_valid,
  output logic [PAGE_BITS-1:0] prog_page,
  output logic flash_erase_go,
  output logic flash_write_go,
  output logic [3:0] lock_bits,
  output logic section_block,
  output logic cpu_halt,
  output logic ready_irq
);

  localparam int DEPTH = 1 << WORD_BITS;
  localparam int PAGE_LSB = PTR_WORD_LSB + WORD_BITS;
  localparam logic [CNT_W-1:0] RUN_LOAD = CNT_W'(PROG_CYCLES - 1);
  localparam logic [2:0] ARM_LOAD = 3'(ARM_CYCLES);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic is_cmd(input logic [4:0] c);
    is_cmd = (c == CMD_REEN) || (c == CMD_LOCK) || (c == CMD_WRITE) ||
             (c == CMD_ERASE) || (c == CMD_LOAD);
  endfunction : is_cmd
  function automatic logic in_stall(input logic [PAGE_BITS-1:0] pg);
    in_stall = 32'(pg) >= STALL_FIRST_PAGE;
  endfunction : in_stall

  // ****************************************************************
  // State and registers
  // ****************************************************************
  fsps_state_t state;
  logic irq_en, busy_flag, run_lock, run_write;
  logic [4:0] cmd;
  logic [15:0] ptr, data;
  logic [2:0] arm_cnt;
  logic [CNT_W-1:0] run_cnt;
  logic [DEPTH-1:0] buf_valid;
  logic acc, wr_ctrl, store_hit, done;
  logic starts_prog, buf_clear, buf_load;
  logic [PAGE_BITS-1:0] ptr_page;
  logic [WORD_BITS-1:0] ptr_word;
  logic [7:0] lpm_byte;

  assign acc = psel && penable && pready;
  assign wr_ctrl = acc && pwrite && (paddr == OFS_CTRL);
  assign store_hit = acc && pwrite && (paddr == OFS_STORE) &&
                     (state == FSPS_ARMED);
  assign done = (state == FSPS_RUN) && (run_cnt == '0);
  assign ptr_page = ptr[PAGE_LSB +: PAGE_BITS];
  assign ptr_word = ptr[PTR_WORD_LSB +: WORD_BITS];
  assign starts_prog = store_hit && ((cmd == CMD_ERASE) ||
                       (cmd == CMD_WRITE) || (cmd == CMD_LOCK));
  assign buf_load = store_hit && (cmd == CMD_LOAD);
  // Re-enable also aborts a load in progress, losing its data
  assign buf_clear = (done && run_write) ||
                     (store_hit && (cmd == CMD_REEN)) ||
                     (eeprom_write && (buf_valid != '0));
  assign section_block = busy_flag;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Read data is fetched in the setup cycle, so the access phase
  // always completes with no wait state.
  always_comb begin
    lpm_byte = ptr[0] ? flash_word[15:8] : flash_word[7:0];
    if (busy_flag && !in_stall(ptr_page)) begin
      lpm_byte = BLOCKED_BYTE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        case (paddr)
          OFS_CTRL: prdata <= {24'h000000, irq_en, busy_flag, 1'b0, cmd};
          OFS_PTR: prdata <= {16'h0000, ptr};
          OFS_DATA: prdata <= {16'h0000, data};
          OFS_STORE: prdata <= '0;
          OFS_LPM: prdata <= {24'h000000, lpm_byte};
          OFS_LOCK: prdata <= {24'h000000, 2'b11, lock_bits, 2'b11};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= PTR_RESET;
      data <= '0;
    end else if (acc && pwrite) begin
      if (paddr == OFS_PTR) begin
        ptr <= pwdata[15:0];
      end
      if (paddr == OFS_DATA) begin
        data <= pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lpm_word_addr <= '0;
    end else begin
      lpm_word_addr <= ptr[15:1];
    end
  end

  // ****************************************************************
  // Control register and sequencer
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en <= 1'b0;
    end else if (wr_ctrl) begin
      irq_en <= pwdata[BIT_IRQ_EN];
    end
  end

  // Command writes are refused while an operation runs; the store
  // enable bit is the only busy indication software needs to poll.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FSPS_IDLE;
      cmd <= '0;
      arm_cnt <= '0;
      run_cnt <= '0;
    end else begin
      case (state)
        FSPS_IDLE, FSPS_ARMED: begin
          if (state == FSPS_ARMED) begin
            arm_cnt <= arm_cnt - 3'h1;
          end
          if (starts_prog) begin
            state <= FSPS_RUN;
            run_cnt <= RUN_LOAD;
          end else if (store_hit) begin
            state <= FSPS_IDLE;
            cmd <= '0;
          end else if (wr_ctrl && is_cmd(pwdata[4:0])) begin
            state <= FSPS_ARMED;
            cmd <= pwdata[4:0];
            arm_cnt <= ARM_LOAD;
          end else if (state == FSPS_ARMED && arm_cnt == 3'h1) begin
            state <= FSPS_IDLE;
            cmd <= '0;
          end
        end
        FSPS_RUN: begin
          run_cnt <= run_cnt - CNT_W'(1);
          if (done) begin
            state <= FSPS_IDLE;
            cmd <= '0;
          end
        end
        default: begin
          state <= FSPS_IDLE;
          cmd <= '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Operation start: latch target and section effects
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_page <= '0;
      run_lock <= 1'b0;
      run_write <= 1'b0;
      flash_erase_go <= 1'b0;
      flash_write_go <= 1'b0;
    end else begin
      flash_erase_go <= 1'b0;
      flash_write_go <= 1'b0;
      if (starts_prog) begin
        run_lock <= (cmd == CMD_LOCK);
        run_write <= (cmd == CMD_WRITE);
        if (cmd != CMD_LOCK) begin
          prog_page <= ptr_page;
        end
        flash_erase_go <= (cmd == CMD_ERASE);
        flash_write_go <= (cmd == CMD_WRITE);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_halt <= 1'b0;
    end else if (done) begin
      cpu_halt <= 1'b0;
    end else if (starts_prog && cmd != CMD_LOCK) begin
      cpu_halt <= in_stall(ptr_page);
    end
  end

  // Busy only for the concurrent section; lock programming never blocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_flag <= 1'b0;
    end else if (starts_prog && cmd != CMD_LOCK &&
                 !in_stall(ptr_page)) begin
      busy_flag <= 1'b1;
    end else if (buf_load || (store_hit && cmd == CMD_REEN)) begin
      busy_flag <= 1'b0;
    end
  end

  // Lock data is taken at completion; the pointer plays no part
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_bits <= LOCK_RESET;
    end else if (done && run_lock) begin
      lock_bits <= lock_bits & data[LOCK_DATA_LSB +: 4];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= irq_en && (cmd[BIT_STORE_EN] == 1'b0) &&
                   !(wr_ctrl && is_cmd(pwdata[4:0])) && !starts_prog;
    end
  end

  // ****************************************************************
  // Temporary page buffer
  // ****************************************************************
  // A clear and a load in one cycle: the clear wins, matching loss of
  // a load that an EEPROM write interrupts.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_valid <= '0;
    end else if (buf_clear) begin
      buf_valid <= '0;
    end else if (buf_load) begin
      buf_valid[ptr_word] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_rd_valid <= 1'b0;
    end else begin
      buf_rd_valid <= buf_valid[buf_rd_addr];
    end
  end

  fsps_page_buf #(
    .WIDTH(16),
    .DEPTH(DEPTH),
    .AW(WORD_BITS)
  ) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .we(buf_load && !buf_clear),
    .waddr(ptr_word),
    .wdata(data),
    .raddr(buf_rd_addr),
    .rdata(buf_rd_data)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seq_start;
    starts_prog;
  endsequence
  sequence seq_done;
    done;
  endsequence

  a_arm_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FSPS_ARMED && arm_cnt == 3'h1 && !store_hit && !wr_ctrl)
    |=> cmd == '0) else $error("arm window not closed");
  a_run_holds_en: assert property (@(posedge clk) disable iff (!rst_n)
    state == FSPS_RUN |-> cmd[BIT_STORE_EN]) else
    $error("store enable dropped while running");
  a_done_clears: assert property (@(posedge clk) disable iff (!rst_n)
    seq_done |=> (cmd == '0) && !cpu_halt && state == FSPS_IDLE) else
    $error("completion left bits set");
  a_page_latched: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FSPS_RUN && $past(state) == FSPS_RUN) |->
    $stable(prog_page)) else $error("target page moved");
  a_lock_no_block: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_start and (cmd == CMD_LOCK)) |=> $stable(busy_flag) &&
    !cpu_halt) else $error("lock set blocked flash");
  a_busy_concur: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_start and (cmd != CMD_LOCK) and !in_stall(ptr_page)) |=>
    busy_flag && !cpu_halt) else $error("busy flag not set");
  a_halt_stall: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_start and (cmd != CMD_LOCK) and in_stall(ptr_page)) |=>
    cpu_halt [*2]) else $error("stall section did not halt");
  a_write_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (seq_done and run_write) |=> buf_valid == '0) else
    $error("buffer kept after page write");
  a_eeprom_drop: assert property (@(posedge clk) disable iff (!rst_n)
    (eeprom_write && buf_valid != '0) |=> buf_valid == '0) else
    $error("eeprom write kept buffer");
  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    (irq_en && state == FSPS_IDLE && !wr_ctrl) [*2] |-> ready_irq) else
    $error("ready interrupt missing");

endmodule : fsps_sequencer

// ===== verification/fsps_flash_model.sv
/*
  Flash array model for the sequencer bench: one page of words that
  erases to all ones and takes loaded buffer words on a page write.
  Assumes the sequencer's registered buffer read port, one cycle late.
*/
`timescale 1ns/10ps
module fsps_flash_model
  import fsps_pkg::*;
#(
  parameter int WORD_BITS = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [14:0] lpm_word_addr,
  output logic [15:0] flash_word,
  output logic [WORD_BITS-1:0] buf_rd_addr,
  input wire logic [15:0] buf_rd_data,
  input wire logic buf_rd_valid,
  input wire logic flash_erase_go,
  input wire logic flash_write_go
);
  // ****************************************************************
  // Storage and copy engine
  // ****************************************************************
  // Page field is not decoded: one page is enough and keeps it small
  localparam int DEPTH = 1 << WORD_BITS;
  logic [15:0] mem [DEPTH];
  logic [WORD_BITS:0] cnt;
  logic copy;

  assign flash_word = mem[lpm_word_addr[WORD_BITS-1:0]];
  assign buf_rd_addr = cnt[WORD_BITS-1:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      copy <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 16'h5AA5;
      end
    end else if (flash_erase_go) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= ERASED_WORD;
      end
    end else if (flash_write_go) begin
      cnt <= '0;
      copy <= 1'b1;
    end else if (copy) begin
      // Unloaded words stay erased, as a real array would keep them
      cnt <= cnt + 1'b1;
      if (cnt != '0 && buf_rd_valid) begin
        mem[cnt[WORD_BITS-1:0] - 1'b1] <= buf_rd_data;
      end
      if (cnt == DEPTH) begin
        copy <= 1'b0;
      end
    end
  end
endmodule : fsps_flash_model

// ===== verification/flash_self_program_sequencer_tb.sv
/*
  Self-checking bench for the flash self-program sequencer: APB tasks
  and a scenario sequence with expected values.
  Assumes the flash array model and a shortened programming time.
*/
`timescale 1ns/10ps
module flash_self_program_sequencer_tb
  import fsps_pkg::*;
;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic clk, rst_n, psel, penable, pwrite, eeprom_write;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, er;
  logic [15:0] flash_word, buf_rd_data, v;
  logic [14:0] lpm_word_addr;
  logic [2:0] buf_rd_addr;
  logic buf_rd_valid, flash_erase_go, flash_write_go;
  logic [6:0] prog_page;
  logic [3:0] lock_bits;
  logic section_block, cpu_halt, ready_irq;
  int num_errors, n_tests, n_erase, cycles;

  fsps_sequencer #(.WORD_BITS(3), .PROG_CYCLES(16)) uut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eeprom_write(eeprom_write),
    .flash_word(flash_word), .lpm_word_addr(lpm_word_addr),
    .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data),
    .buf_rd_valid(buf_rd_valid), .prog_page(prog_page),
    .flash_erase_go(flash_erase_go), .flash_write_go(flash_write_go),
    .lock_bits(lock_bits), .section_block(section_block),
    .cpu_halt(cpu_halt), .ready_irq(ready_irq));

  fsps_flash_model #(.WORD_BITS(3)) fm (
    .clk(clk), .rst_n(rst_n), .lpm_word_addr(lpm_word_addr),
    .flash_word(flash_word), .buf_rd_addr(buf_rd_addr),
    .buf_rd_data(buf_rd_data), .buf_rd_valid(buf_rd_valid),
    .flash_erase_go(flash_erase_go), .flash_write_go(flash_write_go));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic test_done();
    $display("Checks: %0d, mismatches: %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held from setup until the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Read right at the edge: these are the values the slave had before it
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: no pready", $time);
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle();
    repeat (2) @(negedge clk);
  endtask : settle

  // Control write with the irq enable kept, then the store
  task automatic op(input logic [4:0] cmd);
    apb(1'b1, OFS_CTRL, {24'h0, 3'h4, cmd});
    apb(1'b1, OFS_STORE, 32'h0);
  endtask : op

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_CTRL, 32'h0);
      n++;
    end while (rv[BIT_STORE_EN] !== 1'b0 && n < 40);
    if (rv[BIT_STORE_EN] !== 1'b0) begin
      num_errors++;
      $display("CHECK FAILED at %0t: operation never finished", $time);
    end
    settle();
  endtask : wait_done

  function automatic logic [15:0] val(input int i);
    return {8'hA0 + 8'(i), 8'h50 + 8'(i)};
  endfunction : val

  always @(posedge clk) begin
    cycles++;
    if (flash_erase_go === 1'b1) begin
      n_erase++;
    end
    if (cycles == 10000) begin
      num_errors++;
      test_done();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    eeprom_write = 1'b0;
    num_errors = 0;
    n_tests = 0;
    n_erase = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, OFS_LOCK, 32'h0);
    chk(rv, 32'hFF);
    apb(1'b0, 8'h18, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h80);
    settle();
    chk(ready_irq, 1'b1);
    // Buffer filled out of order, before the erase
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_PTR, 32'h20 + 32'((i * 3) % 8 * 2));
      apb(1'b1, OFS_DATA, 32'(val((i * 3) % 8)));
      op(CMD_LOAD);
    end
    apb(1'b1, OFS_PTR, 32'h20);
    op(CMD_ERASE);
    settle();
    chk(section_block, 1'b1);
    chk(cpu_halt, 1'b0);
    chk(ready_irq, 1'b0);
    apb(1'b1, OFS_PTR, 32'h30);
    chk(prog_page, 7'h02);
    apb(1'b0, OFS_LPM, 32'h0);
    chk(rv, 32'hFF);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rv[4:0], 5'h03);
    wait_done();
    chk(rv, 32'hC0);
    chk(ready_irq, 1'b1);
    apb(1'b1, OFS_PTR, 32'h20);
    op(CMD_WRITE);
    settle();
    chk(section_block, 1'b1);
    chk(cpu_halt, 1'b0);
    wait_done();
    op(CMD_REEN);
    settle();
    chk(section_block, 1'b0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, OFS_PTR, 32'h20 + 32'(i));
      apb(1'b0, OFS_LPM, 32'h0);
      v = val(i / 2);
      chk(rv, 32'(i[0] ? v[15:8] : v[7:0]));
    end
    // Stalling page: halt, then an aborted load
    apb(1'b1, OFS_PTR, 32'h780);
    op(CMD_ERASE);
    settle();
    chk(cpu_halt, 1'b1);
    chk(section_block, 1'b0);
    wait_done();
    chk(cpu_halt, 1'b0);
    apb(1'b1, OFS_DATA, 32'h1234);
    op(CMD_LOAD);
    @(posedge clk);
    eeprom_write <= 1'b1;
    @(posedge clk);
    eeprom_write <= 1'b0;
    op(CMD_WRITE);
    settle();
    chk(cpu_halt, 1'b1);
    wait_done();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_PTR, 32'h780 + 32'(i));
      apb(1'b0, OFS_LPM, 32'h0);
      chk(rv, 32'hFF);
    end
    apb(1'b1, OFS_PTR, 32'h1);
    apb(1'b1, OFS_DATA, 32'hE7);
    op(CMD_LOCK);
    settle();
    chk(section_block, 1'b0);
    chk(cpu_halt, 1'b0);
    wait_done();
    apb(1'b0, OFS_LOCK, 32'h0);
    chk(rv, 32'hE7);
    apb(1'b1, OFS_PTR, 32'h7FF);
    apb(1'b1, OFS_DATA, 32'hFB);
    op(CMD_LOCK);
    wait_done();
    chk(lock_bits, 4'h8);
    // Store too late, then a code that is not a command
    apb(1'b1, OFS_CTRL, 32'h83);
    repeat (3) @(posedge clk);
    apb(1'b1, OFS_STORE, 32'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rv, 32'h80);
    apb(1'b1, OFS_CTRL, 32'h87);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rv, 32'h80);
    chk(n_erase, 32'h2);
    test_done();
  end
endmodule : flash_self_program_sequencer_tb
